// file: flags_unit.sv
`timescale 1ns/100ps
`default_nettype none
`include "flags_map.svh"

// Notes on behaviour
// - carry flag set on carry or borrow out of result top bit.
// - parity flag set when low result byte has even ones count.
// - nibble carry flag set on carry or borrow out of bit 3.
// - zero flag set when result is zero, cleared otherwise.
// - sign flag copies the result's top bit.
// - overflow flag set when signed result does not fit.
// - only carry among status flags is directly writable: set, clear, complement ops.
// - bit test ops copy the selected bit into carry.
// - add-with-carry and subtract-with-borrow consume the carry flag.
// - conditional ops evaluate status flags as their condition.
// - direction bit one steps strings down, zero steps up.
// - set and clear direction ops drive the direction bit.
// - maskable interrupts accepted only while interrupt enable is one.
// - single step mode active while the step flag is one.
// - I/O access allowed only when privilege <= I/O privilege level.
// - I/O privilege level changes only by pop or return at level 0.
// - task link bit shows whether current task is chained.
// - virtual mode bit one selects compatibility mode.
// - alignment checks need both flag bit and control bit.
// - virtual interrupt bit used with pending only under extensions.
// - virtual pending bit is only read, changed by software alone.
// - feature probe bit freely writable by programs.
// - reset or init loads the word with 00000002h.
// - bits 1, 3, 5, 15, 22-31 reserved and fixed.
module flags_unit
    import flags_pkg::*;
(
    input  wire logic        clk_sys_i,
    input  wire logic        rstn_i,
    input  wire logic        init_i,
    input  wire logic        op_valid_i,
    input  var  op_t         op_code_i,
    input  var  size_t       op_size_i,
    input  wire logic [31:0] operand_a_i,
    input  wire logic [31:0] operand_b_i,
    input  wire logic        bit_value_i,
    input  wire logic [31:0] pop_value_i,
    input  var  cond_t       cond_i,
    input  wire logic [1:0]  priv_level_i,
    input  wire logic        task_load_i,
    input  wire logic        task_link_i,
    input  wire logic        irq_req_i,
    input  wire logic        align_mask_i,
    input  wire logic        virt_ext_i,
    output logic [31:0]      flags_o,
    output logic [31:0]      result_o,
    output logic             cond_true_o,
    output logic             string_step_down_o,
    output logic             irq_accept_o,
    output logic             single_step_o,
    output logic             io_access_ok_o,
    output logic             task_linked_o,
    output logic             v86_mode_o,
    output logic             align_check_o,
    output logic             virq_active_o
);

    function automatic logic eval_cond(input cond_t c,
                                       input logic [31:0] f);
        logic r;
        r = 1'b0;
        unique case (c[3:1])
            3'h0: r = f[`OVF_POS];
            3'h1: r = f[`CARRY_POS];
            3'h2: r = f[`ZERO_POS];
            3'h3: r = f[`CARRY_POS] | f[`ZERO_POS];
            3'h4: r = f[`SIGN_POS];
            3'h5: r = f[`PARITY_POS];
            3'h6: r = f[`SIGN_POS] ^ f[`OVF_POS];
            3'h7: r = (f[`SIGN_POS] ^ f[`OVF_POS]) | f[`ZERO_POS];
        endcase
        eval_cond = r ^ c[0];
    endfunction

    alu_if alu ();

    result_flags_calc u_calc (
        .bus (alu.calc)
    );

    state_t st;
    state_t next_st;
    logic   is_arith;
    logic   is_pop;
    logic [31:0] pop_keep;

    assign alu.a = operand_a_i;
    assign alu.b = operand_b_i;
    assign alu.op = op_code_i;
    assign alu.size = op_size_i;
    // chained carry into multi-word arithmetic
    assign alu.cin = ((op_code_i == OP_ADC) || (op_code_i == OP_SUB_BORROW))
                     && st.flags[`CARRY_POS];

    always_comb begin
        next_st = st;
        is_arith = (op_code_i inside {OP_ADD, OP_ADC, OP_SUB, OP_SUB_BORROW,
                                      OP_AND, OP_OR, OP_XOR});
        is_pop = (op_code_i == OP_POP_FLAGS) || (op_code_i == OP_INT_RETURN);
        pop_keep = `RESERVED_MASK | `V86_MASK;
        if (priv_level_i == `TOP_PRIV) begin
            pop_keep = `RESERVED_MASK;
            if (op_code_i == OP_POP_FLAGS) begin
                pop_keep = `RESERVED_MASK | `V86_MASK;
            end
        end else begin
            pop_keep = `RESERVED_MASK | `V86_MASK | `PRIV_MASK;
        end
        if (op_valid_i) begin
            if (is_arith) begin
                next_st.result = alu.result;
                next_st.flags[`CARRY_POS] = alu.carry;
                next_st.flags[`PARITY_POS] = alu.parity;
                next_st.flags[`NIBBLE_POS] = alu.nibble;
                next_st.flags[`ZERO_POS] = alu.zero;
                next_st.flags[`SIGN_POS] = alu.sign;
                next_st.flags[`OVF_POS] = alu.ovf;
            end
            unique case (op_code_i)
                OP_SET_CARRY: next_st.flags[`CARRY_POS] = 1'b1;
                OP_CLR_CARRY: next_st.flags[`CARRY_POS] = 1'b0;
                OP_FLIP_CARRY: next_st.flags[`CARRY_POS] =
                            ~st.flags[`CARRY_POS];
                OP_BIT_TEST, OP_BIT_SET, OP_BIT_RESET, OP_BIT_FLIP:
                    next_st.flags[`CARRY_POS] = bit_value_i;
                OP_SET_DIR: next_st.flags[`DIR_POS] = 1'b1;
                OP_CLR_DIR: next_st.flags[`DIR_POS] = 1'b0;
                OP_POP_FLAGS, OP_INT_RETURN: ;
                default: ;
            endcase
            if (is_pop) begin
                // software image loads probe, pending and control bits
                next_st.flags = (st.flags & pop_keep)
                              | (pop_value_i & ~pop_keep);
            end
        end
        if (task_load_i) begin
            next_st.flags[`TASK_POS] = task_link_i;
        end
        next_st.flags = (next_st.flags & ~`RESERVED_MASK)
                      | `FLAGS_RESET;
        if (init_i) begin
            next_st.flags = `FLAGS_RESET;
        end
        next_st.cond_true = eval_cond(cond_i, next_st.flags);
        next_st.irq_accept = irq_req_i
                             && next_st.flags[`IRQ_EN_POS];
        next_st.io_ok = (priv_level_i
                         <= next_st.flags[`PRIV_HI:`PRIV_LO]);
        next_st.align_chk = align_mask_i
                            && next_st.flags[`ALIGN_POS];
        next_st.virq_active = virt_ext_i && next_st.flags[`VIRQ_EN_POS]
                              && next_st.flags[`VIRQ_PEND_POS];
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st <= '0;
            st.flags <= `FLAGS_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign flags_o = st.flags;
    assign result_o = st.result;
    assign cond_true_o = st.cond_true;
    assign string_step_down_o = st.flags[`DIR_POS];
    assign irq_accept_o = st.irq_accept;
    assign single_step_o = st.flags[`STEP_POS];
    assign io_access_ok_o = st.io_ok;
    assign task_linked_o = st.flags[`TASK_POS];
    assign v86_mode_o = st.flags[`V86_POS];
    assign align_check_o = st.align_chk;
    assign virq_active_o = st.virq_active;

    sequence carry_op_s(op_t o);
        op_valid_i && !init_i && (op_code_i == o);
    endsequence

    sequence bit_test_s;
        op_valid_i && !init_i
        && (op_code_i inside {OP_BIT_TEST, OP_BIT_SET, OP_BIT_RESET,
                              OP_BIT_FLIP});
    endsequence

    sequence quiet_s;
        !op_valid_i && !init_i && !task_load_i;
    endsequence

    reserved_bits_a: assert property (
        @(posedge clk_sys_i) disable iff (!rstn_i)
        (flags_o & `RESERVED_MASK) == `FLAGS_RESET)
        else $error("reserved flag bits not fixed");

    init_value_a: assert property (
        @(posedge clk_sys_i) disable iff (!rstn_i)
        init_i |=> flags_o == `FLAGS_RESET)
        else $error("init did not load reset word");

    carry_set_a: assert property (
        @(posedge clk_sys_i) disable iff (!rstn_i)
        carry_op_s(OP_SET_CARRY) |=> flags_o[`CARRY_POS])
        else $error("set carry failed");

    carry_flip_a: assert property (
        @(posedge clk_sys_i) disable iff (!rstn_i)
        carry_op_s(OP_FLIP_CARRY) |=>
            flags_o[`CARRY_POS] != $past(flags_o[`CARRY_POS]))
        else $error("complement carry failed");

    bit_copy_a: assert property (
        @(posedge clk_sys_i) disable iff (!rstn_i)
        bit_test_s |=> flags_o[`CARRY_POS] == $past(bit_value_i))
        else $error("bit test did not copy carry");

    zero_flag_a: assert property (
        @(posedge clk_sys_i) disable iff (!rstn_i)
        carry_op_s(OP_ADD) ##1 1'b1 |->
            flags_o[`ZERO_POS] == (result_o == 32'h0000_0000))
        else $error("zero flag mismatch");

    flags_hold_a: assert property (
        @(posedge clk_sys_i) disable iff (!rstn_i)
        quiet_s |=> $stable(flags_o))
        else $error("flags changed without update");

    priv_guard_a: assert property (
        @(posedge clk_sys_i) disable iff (!rstn_i)
        (priv_level_i != `TOP_PRIV) && !init_i |=>
            $stable(flags_o[`PRIV_HI:`PRIV_LO]))
        else $error("io privilege changed at low privilege");

    pending_kept_a: assert property (
        @(posedge clk_sys_i) disable iff (!rstn_i)
        !(op_valid_i && (op_code_i inside {OP_POP_FLAGS, OP_INT_RETURN}))
        && !init_i
        |=> $stable(flags_o[`VIRQ_PEND_POS]))
        else $error("pending bit changed by hardware");

    io_check_a: assert property (
        @(posedge clk_sys_i) disable iff (!rstn_i)
        rstn_i |=> io_access_ok_o ==
            ($past(priv_level_i) <= flags_o[`PRIV_HI:`PRIV_LO]))
        else $error("io access permission wrong");

    irq_gate_a: assert property (
        @(posedge clk_sys_i) disable iff (!rstn_i)
        irq_accept_o |-> flags_o[`IRQ_EN_POS])
        else $error("interrupt accepted while disabled");

    align_gate_a: assert property (
        @(posedge clk_sys_i) disable iff (!rstn_i)
        rstn_i |=> align_check_o ==
            ($past(align_mask_i) && flags_o[`ALIGN_POS]))
        else $error("alignment check gating wrong");

endmodule

`default_nettype wire

// file: flags_map.svh
`ifndef FLAGS_MAP_SVH
`define FLAGS_MAP_SVH

// bit positions inside the flags word
`define CARRY_POS     0
`define FIXED_ONE_POS 1
`define PARITY_POS    2
`define NIBBLE_POS    4
`define ZERO_POS      6
`define SIGN_POS      7
`define STEP_POS      8
`define IRQ_EN_POS    9
`define DIR_POS       10
`define OVF_POS       11
`define PRIV_LO       12
`define PRIV_HI       13
`define TASK_POS      14
`define RESUME_POS    16
`define V86_POS       17
`define ALIGN_POS     18
`define VIRQ_EN_POS   19
`define VIRQ_PEND_POS 20
`define PROBE_POS     21

// word values
`define FLAGS_RESET   32'h0000_0002
`define RESERVED_MASK 32'hFFC0_802A
`define PRIV_MASK     32'h0000_3000
`define V86_MASK      32'h0002_0000
`define SIZE_MASK_B   32'h0000_00FF
`define SIZE_MASK_W   32'h0000_FFFF
`define SIZE_MASK_D   32'hFFFF_FFFF
`define TOP_PRIV      2'h0

`endif

// file: flags_pkg.sv
package flags_pkg;

    typedef enum logic [4:0] {
        OP_NONE = 5'b00000,
        OP_ADD  = 5'b00001,
        OP_ADC  = 5'b00010,
        OP_SUB  = 5'b00011,
        OP_SUB_BORROW = 5'b00100,
        OP_AND  = 5'b00101,
        OP_OR   = 5'b00110,
        OP_XOR  = 5'b00111,
        OP_SET_CARRY  = 5'b01000,
        OP_CLR_CARRY  = 5'b01001,
        OP_FLIP_CARRY = 5'b01010,
        OP_BIT_TEST   = 5'b01011,
        OP_BIT_SET    = 5'b01100,
        OP_BIT_RESET  = 5'b01101,
        OP_BIT_FLIP   = 5'b01110,
        OP_SET_DIR    = 5'b01111,
        OP_CLR_DIR    = 5'b10000,
        OP_POP_FLAGS  = 5'b10001,
        OP_INT_RETURN = 5'b10010
    } op_t;

    typedef enum logic [1:0] {
        SZ_BYTE  = 2'b00,
        SZ_WORD  = 2'b01,
        SZ_DWORD = 2'b10
    } size_t;

    typedef enum logic [3:0] {
        CC_O   = 4'b0000,
        CC_NO  = 4'b0001,
        CC_B   = 4'b0010,
        CC_NB  = 4'b0011,
        CC_Z   = 4'b0100,
        CC_NZ  = 4'b0101,
        CC_BE  = 4'b0110,
        CC_NBE = 4'b0111,
        CC_S   = 4'b1000,
        CC_NS  = 4'b1001,
        CC_P   = 4'b1010,
        CC_NP  = 4'b1011,
        CC_L   = 4'b1100,
        CC_NL  = 4'b1101,
        CC_LE  = 4'b1110,
        CC_NLE = 4'b1111
    } cond_t;

    typedef struct packed {
        logic [31:0] flags;
        logic [31:0] result;
        logic        cond_true;
        logic        irq_accept;
        logic        io_ok;
        logic        align_chk;
        logic        virq_active;
    } state_t;

endpackage

// file: alu_if.sv
`timescale 1ns/100ps
`default_nettype none

interface alu_if;
    import flags_pkg::*;
    logic [31:0] a;
    logic [31:0] b;
    op_t         op;
    size_t       size;
    logic        cin;
    logic [31:0] result;
    logic        carry;
    logic        nibble;
    logic        ovf;
    logic        zero;
    logic        sign;
    logic        parity;

    modport calc (input a, b, op, size, cin,
                  output result, carry, nibble, ovf, zero, sign, parity);
    modport user (output a, b, op, size, cin,
                  input result, carry, nibble, ovf, zero, sign, parity);
endinterface

`default_nettype wire

// file: result_flags_calc.sv
`timescale 1ns/100ps
`default_nettype none
`include "flags_map.svh"

module result_flags_calc
    import flags_pkg::*;
(
    alu_if.calc bus
);

    // picks the bit at the top of the operand, or one above it
    function automatic logic size_bit(input logic [32:0] v,
                                      input size_t s,
                                      input logic above);
        logic [5:0] idx;
        idx = 6'h0;
        unique case (s)
            SZ_BYTE: idx = 6'h07;
            SZ_WORD: idx = 6'h0F;
            default: idx = 6'h1F;
        endcase
        size_bit = v[idx + {5'h0, above}];
    endfunction

    logic [31:0] mask;
    logic [31:0] am;
    logic [31:0] bm;
    logic [32:0] wide;
    logic [31:0] res;
    logic        arith;
    logic        sub;

    always_comb begin
        unique case (bus.size)
            SZ_BYTE: mask = `SIZE_MASK_B;
            SZ_WORD: mask = `SIZE_MASK_W;
            default: mask = `SIZE_MASK_D;
        endcase
        am = bus.a & mask;
        bm = bus.b & mask;
        sub = (bus.op == OP_SUB) || (bus.op == OP_SUB_BORROW);
        arith = sub || (bus.op == OP_ADD) || (bus.op == OP_ADC);
        if (sub) begin
            wide = {1'b0, am} - {1'b0, bm} - {32'h0000_0000, bus.cin};
        end else begin
            wide = {1'b0, am} + {1'b0, bm} + {32'h0000_0000, bus.cin};
        end
        unique case (bus.op)
            OP_AND:  res = am & bm;
            OP_OR:   res = am | bm;
            OP_XOR:  res = am ^ bm;
            default: res = wide[31:0] & mask;
        endcase
        bus.result = res;
        bus.carry = arith && size_bit(wide, bus.size, 1'b1);
        bus.nibble = arith && ((am[4] ^ bm[4]) ^ res[4]);
        if (sub) begin
            bus.ovf = arith && size_bit({1'b0, (am ^ bm) & (am ^ res)},
                                        bus.size, 1'b0);
        end else begin
            bus.ovf = arith && size_bit({1'b0, ~(am ^ bm) & (am ^ res)},
                                        bus.size, 1'b0);
        end
        bus.zero = (res == 32'h0000_0000);
        bus.sign = size_bit({1'b0, res}, bus.size, 1'b0);
        bus.parity = ~^res[7:0];
    end

endmodule

`default_nettype wire

// file: exec_model.sv
`timescale 1ns/100ps
`default_nettype none

// execution side of the flags unit: one op request per call, set on a clock edge
module exec_model
    import flags_pkg::*;
(
    output var logic        op_valid_o,
    output var op_t         op_code_o,
    output var size_t       op_size_o,
    output var logic [31:0] operand_a_o,
    output var logic [31:0] operand_b_o,
    output var logic        bit_value_o,
    output var logic [31:0] pop_value_o,
    output var cond_t       cond_o,
    output var logic [1:0]  priv_level_o,
    output var logic        task_load_o,
    output var logic        task_link_o,
    output var logic        irq_req_o,
    output var logic        align_mask_o,
    output var logic        virt_ext_o
);
    task automatic apply(input logic v, input op_t op, input size_t sz,
                         input logic [31:0] a, input logic [31:0] b,
                         input logic bv, input logic [31:0] pop,
                         input cond_t cc, input logic [1:0] lvl,
                         input logic tl, input logic tk, input logic irq,
                         input logic amk, input logic vx);
        op_valid_o  <= v;
        op_code_o   <= op;
        op_size_o   <= sz;
        operand_a_o <= a;
        operand_b_o <= b;
        bit_value_o <= bv;
        pop_value_o <= pop;
        cond_o      <= cc;
        priv_level_o <= lvl;
        task_load_o  <= tl;
        task_link_o  <= tk;
        irq_req_o    <= irq;
        align_mask_o <= amk;
        virt_ext_o   <= vx;
    endtask
endmodule

`default_nettype wire

// file: testbench.sv
`timescale 1ns/100ps
`default_nettype none
`include "flags_map.svh"

module testbench
    import flags_pkg::*;
;
    typedef struct {
        logic v; op_t op; size_t sz; logic [31:0] a; logic [31:0] b;
        logic bv; logic [31:0] pop; cond_t cc; logic [1:0] lvl;
        logic tl; logic tk; logic irq; logic amk; logic vx; logic init;
    } stim_t;

    logic        clk_sys_i = 1'h0;
    logic        rstn_i = 1'h0;
    logic        init_i = 1'h0;
    logic        vld, bv, tl, tk, irq, amk, vx;
    op_t         opc;
    size_t       sz;
    cond_t       cc;
    logic [1:0]  lvl;
    logic [31:0] a, b, pop, flags_o, result_o;
    logic        c_o, sd_o, irq_o, st_o, io_o, tsk_o, v86_o, al_o, vi_o;
    wire logic [8:0] gv = {c_o, sd_o, irq_o, st_o, io_o, tsk_o, v86_o,
                           al_o, vi_o};
    logic [31:0] ef, er;
    logic [8:0]  ev;
    logic        have, rk;
    int          miscompares = 0;
    int          checks_done = 0;
    int          cycles = 0;

    always #12.5 clk_sys_i = ~clk_sys_i;

    exec_model exec_model_inst (.op_valid_o(vld), .op_code_o(opc),
        .op_size_o(sz), .operand_a_o(a), .operand_b_o(b), .bit_value_o(bv),
        .pop_value_o(pop), .cond_o(cc), .priv_level_o(lvl), .task_load_o(tl),
        .task_link_o(tk), .irq_req_o(irq), .align_mask_o(amk),
        .virt_ext_o(vx));

    flags_unit flags_unit_inst (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
        .init_i(init_i), .op_valid_i(vld), .op_code_i(opc), .op_size_i(sz),
        .operand_a_i(a), .operand_b_i(b), .bit_value_i(bv),
        .pop_value_i(pop), .cond_i(cc), .priv_level_i(lvl), .task_load_i(tl),
        .task_link_i(tk), .irq_req_i(irq), .align_mask_i(amk),
        .virt_ext_i(vx),
        .flags_o(flags_o), .result_o(result_o), .cond_true_o(c_o),
        .string_step_down_o(sd_o), .irq_accept_o(irq_o),
        .single_step_o(st_o), .io_access_ok_o(io_o), .task_linked_o(tsk_o),
        .v86_mode_o(v86_o), .align_check_o(al_o), .virq_active_o(vi_o));

    task automatic summarize();
        $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    always @(posedge clk_sys_i) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            summarize();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    function automatic logic [31:0] rv();
        case ($urandom_range(0, 3))
            0: return 32'hFFFF_FFFF;
            1: return 32'h0000_007F;
            2: return 32'h8000_0000;
            default: return $urandom;
        endcase
    endfunction

    function automatic stim_t mk(op_t op, size_t z, logic [31:0] x,
                                 logic [31:0] y, logic [1:0] p);
        stim_t s;
        s = '{op != OP_NONE, op, z, x, y, 1'h0, x, CC_O, p,
              1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0};
        return s;
    endfunction

    function automatic stim_t rnd();
        stim_t s;
        s = mk(op_t'($urandom_range(0, 18)), size_t'($urandom_range(0, 2)),
               rv(), rv(), 2'($urandom_range(0, 3)));
        s.v = $urandom_range(0, 7) != 0;
        s.bv = $urandom_range(0, 1);
        s.pop = $urandom;
        s.cc = cond_t'($urandom_range(0, 15));
        s.tl = $urandom_range(0, 7) == 0;
        s.tk = $urandom_range(0, 1);
        s.irq = $urandom_range(0, 1);
        s.amk = $urandom_range(0, 1);
        s.vx = $urandom_range(0, 1);
        s.init = $urandom_range(0, 99) == 0;
        return s;
    endfunction

    // result and status bits {res, of, sf, zf, af, pf, cf}
    function automatic logic [37:0] arith(stim_t s, logic c0);
        logic [32:0] m, x, y, r;
        logic [31:0] rr;
        logic        c, ar, ov;
        int          w;
        w = (s.sz == SZ_BYTE) ? 8 : (s.sz == SZ_WORD) ? 16 : 32;
        m = (33'h0_0000_0001 << w) - 33'h0_0000_0001;
        x = {1'h0, s.a} & m;
        y = {1'h0, s.b} & m;
        c = (s.op == OP_ADC || s.op == OP_SUB_BORROW) ? c0 : 1'h0;
        case (s.op)
            OP_ADD, OP_ADC: r = x + y + 33'(c);
            OP_SUB, OP_SUB_BORROW: r = x - y - 33'(c);
            OP_AND: r = x & y;
            OP_OR: r = x | y;
            default: r = x ^ y;
        endcase
        ar = s.op inside {OP_ADD, OP_ADC, OP_SUB, OP_SUB_BORROW};
        rr = r[31:0] & m[31:0];
        ov = (s.op inside {OP_ADD, OP_ADC}) ? (x[w-1] == y[w-1])
                                             : (x[w-1] != y[w-1]);
        ov = ar && ov && (rr[w-1] != x[w-1]);
        return {rr, ov, rr[w-1], rr == 32'h0000_0000,
                ar & (x[4] ^ y[4] ^ r[4]), ~^rr[7:0], ar & r[w]};
    endfunction

    function automatic logic [31:0] nflags(logic [31:0] f, stim_t s,
                                           logic [5:0] t);
        logic [31:0] n, k;
        n = f;
        if (s.v) case (s.op)
            OP_ADD, OP_ADC, OP_SUB, OP_SUB_BORROW, OP_AND, OP_OR, OP_XOR:
                {n[11], n[7], n[6], n[4], n[2], n[0]} = t;
            OP_SET_CARRY: n[0] = 1'h1;
            OP_CLR_CARRY: n[0] = 1'h0;
            OP_FLIP_CARRY: n[0] = ~f[0];
            OP_BIT_TEST, OP_BIT_SET, OP_BIT_RESET, OP_BIT_FLIP: n[0] = s.bv;
            OP_SET_DIR: n[10] = 1'h1;
            OP_CLR_DIR: n[10] = 1'h0;
            OP_POP_FLAGS, OP_INT_RETURN: begin
                k = (s.lvl != `TOP_PRIV) ? `PRIV_MASK : 32'h0000_0000;
                if (!(s.op == OP_INT_RETURN && s.lvl == `TOP_PRIV))
                    k = k | `V86_MASK;
                n = ((s.pop & ~k) | (f & k)) & ~`RESERVED_MASK;
                n = n | `FLAGS_RESET;
            end
            default: ;
        endcase
        if (s.tl)
            n[14] = s.tk;
        if (s.init)
            n = `FLAGS_RESET;
        return n;
    endfunction

    function automatic logic cond(cond_t c, logic [31:0] f);
        logic [7:0] t;
        t = {f[6] | (f[7] ^ f[11]), f[7] ^ f[11], f[2], f[7],
             f[0] | f[6], f[6], f[0], f[11]};
        return t[c[3:1]] ^ c[0];
    endfunction

    task automatic drive(input stim_t s);
        init_i <= s.init;
        exec_model_inst.apply(s.v, s.op, s.sz, s.a, s.b, s.bv, s.pop, s.cc,
                              s.lvl, s.tl, s.tk, s.irq, s.amk, s.vx);
    endtask

    // outputs seen after this edge belong to the previous call's stimulus
    task automatic cyc(input stim_t s);
        logic [37:0] t;
        @(posedge clk_sys_i);
        drive(s);
        #1;
        if (have) begin
            chk(flags_o[7:0], ef[7:0]);
            chk(flags_o[15:8], ef[15:8]);
            chk(flags_o[31:16], ef[31:16]);
            if (rk)
                chk(result_o, er);
            chk(gv, ev);
        end
        t = arith(s, ef[0]);
        if (s.init)
            rk = 1'h0;
        else if (s.v && s.op inside {[OP_ADD:OP_XOR]}) begin
            er = t[37:6];
            rk = 1'h1;
        end
        ef = nflags(ef, s, t[5:0]);
        ev = {cond(s.cc, ef), ef[10], s.irq & ef[9], ef[8],
              s.lvl <= ef[13:12], ef[14], ef[17], s.amk & ef[18],
              s.vx & ef[19] & ef[20]};
        have = 1'h1;
    endtask

    task automatic do_reset(input int n);
        @(posedge clk_sys_i);
        rstn_i <= 1'h0;
        drive(mk(OP_NONE, SZ_BYTE, 32'h0000_0000, 32'h0000_0000, 2'h0));
        repeat (n) @(posedge clk_sys_i);
        #1;
        chk(flags_o, `FLAGS_RESET);
        chk(result_o, 32'h0000_0000);
        chk(gv, 9'h000);
        @(posedge clk_sys_i);
        rstn_i <= 1'h1;
        have = 1'h0;
        rk = 1'h1;
        ef = `FLAGS_RESET;
        er = 32'h0000_0000;
    endtask

    initial begin
        stim_t s, z;
        z = mk(OP_NONE, SZ_BYTE, 32'h0000_0000, 32'h0000_0000, 2'h0);
        drive(z);
        void'($urandom(15109));
        do_reset(12);
        cyc(mk(OP_ADD, SZ_BYTE, 32'h0000_00FF, 32'h0000_0001, 2'h0));
        cyc(z);
        chk(flags_o, 32'h0000_0057);
        cyc(mk(OP_SET_CARRY, SZ_DWORD, 32'h0000_0000, 32'h0000_0000, 2'h0));
        cyc(mk(OP_ADC, SZ_DWORD, 32'hFFFF_FFFF, 32'h0000_0000, 2'h0));
        cyc(mk(OP_ADC, SZ_DWORD, 32'h0000_0000, 32'h0000_0000, 2'h0));
        cyc(mk(OP_SUB_BORROW, SZ_WORD, 32'h0000_0000, 32'h0000_0001, 2'h0));
        cyc(mk(OP_SUB_BORROW, SZ_WORD, 32'h0000_0000, 32'h0000_0000, 2'h0));
        for (int c = 0; c < 4; c++) begin
            cyc(mk(OP_POP_FLAGS, SZ_DWORD, 32'hFFFF_FFFF, 32'h0000_0000,
                   2'(c)));
            cyc(mk(OP_INT_RETURN, SZ_DWORD, 32'hFFFF_FFFF, 32'h0000_0000,
                   2'(c)));
            cyc(mk(OP_INT_RETURN, SZ_DWORD, 32'h0000_0000, 32'h0000_0000,
                   2'(c)));
        end
        for (int i = 0; i < 19; i++) begin
            s = rnd();
            s.v = 1'h1;
            s.op = op_t'(i);
            s.init = 1'h0;
            cyc(s);
        end
        s = mk(OP_POP_FLAGS, SZ_DWORD, 32'h0000_0000, 32'h0000_0000, 2'h0);
        s.tl = 1'h1;
        s.tk = 1'h1;
        cyc(s);
        s = mk(OP_ADD, SZ_BYTE, 32'h0000_00FF, 32'h0000_0001, 2'h0);
        s.init = 1'h1;
        cyc(s);
        repeat (3000) cyc(rnd());
        do_reset(2);
        repeat (500) cyc(rnd());
        cyc(z);
        summarize();
    end
endmodule

`default_nettype wire
